// file: vbum_pkg.sv
package vbum_pkg;
   // Table geometry
   localparam int NPORT = 11;
   localparam int PORT_W = 4;
   localparam int TAG_W = 16;
   localparam int FID_W = 17;
   localparam int NSLOT = 16;
   localparam int NAGGR = 16;
   localparam int VID_W = 6;
   localparam int MAC_AW = 5;
   // Empty filter-id slot marker
   localparam logic [FID_W-1:0] FID_UNUSED = 17'h1_FFFF;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_RANGE = 8'h04;
   localparam logic [7:0] REG_PSET = 8'h08;
   localparam logic [7:0] REG_RMASK = 8'h0C;
   localparam logic [7:0] REG_SPORTS = 8'h10;
   localparam logic [7:0] REG_ID_SEL = 8'h14;
   localparam logic [7:0] REG_ID_VAL = 8'h18;
   localparam logic [7:0] REG_V_ADDR = 8'h1C;
   localparam logic [7:0] REG_V_DAT0 = 8'h20;
   localparam logic [7:0] REG_V_DAT1 = 8'h24;
   localparam logic [7:0] REG_IN_FILT = 8'h28;
   localparam logic [7:0] REG_FWD_EN = 8'h2C;
   localparam logic [7:0] REG_LEARN_EN = 8'h30;
   localparam logic [7:0] REG_P_SEL = 8'h34;
   localparam logic [7:0] REG_P_CFG = 8'h38;
   localparam logic [7:0] REG_A_SEL = 8'h3C;
   localparam logic [7:0] REG_A_MASK = 8'h40;
   localparam logic [7:0] REG_M_ADDR = 8'h44;
   localparam logic [7:0] REG_M_DATA = 8'h48;
   localparam logic [7:0] REG_STATUS = 8'h4C;
   // Control register bit positions
   localparam int C_BULK_GO = 0;
   localparam int C_TBL_GO = 1;
   localparam int C_RING_EN = 2;
   localparam int C_IDLIST_EN = 3;
   localparam int C_IDFILT_EN = 4;
   localparam int C_PFILT_EN = 5;
   localparam int C_DEL_EN = 6;
   localparam int C_IRQ_EN = 7;
   localparam int C_DONE = 8;
   // Field positions inside words
   localparam int RANGE_LAST_LSB = 16;
   localparam int VD0_MEMBER_LSB = 16;
   localparam int PCFG_EGR_LSB = 4;
   localparam int MDATA_PORT_LSB = 17;
   localparam int MDATA_VALID = 31;
   localparam int STAT_FOUND_LSB = 8;
   // Engine states
   typedef enum logic [0:0] {ENG_IDLE, ENG_RUN} vbum_eng_state_t;
endpackage : vbum_pkg

// file: vbum_scan_if.sv
`timescale 1ns/1ns
interface vbum_scan_if #(parameter int AW = vbum_pkg::MAC_AW);
   // Command and completion
   logic go;
   logic busy;
   logic done;
   logic [AW:0] found;
   // Scan configuration
   logic id_filter_en;
   logic id_list_en;
   logic port_filter_en;
   logic delete_en;
   logic [vbum_pkg::NPORT-1:0] port_mask;
   logic [vbum_pkg::FID_W-1:0] id_list [vbum_pkg::NSLOT];
   // Table walk
   logic [AW-1:0] idx;
   logic entry_valid;
   logic [vbum_pkg::FID_W-1:0] entry_fid;
   logic [vbum_pkg::PORT_W-1:0] entry_port;
   logic del;
   modport table_side (output go, id_filter_en, id_list_en, port_filter_en, delete_en,
      port_mask, id_list, entry_valid, entry_fid, entry_port,
      input busy, done, found, idx, del);
   modport scanner (input go, id_filter_en, id_list_en, port_filter_en, delete_en,
      port_mask, id_list, entry_valid, entry_fid, entry_port,
      output busy, done, found, idx, del);
endinterface : vbum_scan_if

// file: vbum_scan.sv
`timescale 1ns/1ns
module vbum_scan #(
   parameter int AW = vbum_pkg::MAC_AW
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Table side
   vbum_scan_if.scanner sif
);
   vbum_pkg::vbum_eng_state_t state; // Walk state
   logic [vbum_pkg::NSLOT-1:0] slot_hit; // Per-slot id match
   logic id_ok; // Entry passes id filter
   logic port_ok; // Entry passes port filter
   logic match; // Entry selected
   logic last; // Final entry reached

   // One comparator per list slot; all-ones slots never match
   for (genvar g = 0; g < vbum_pkg::NSLOT; g++) begin : g_slot
      assign slot_hit[g] = (sif.id_list[g] != vbum_pkg::FID_UNUSED) &&
         (sif.id_list[g] == sif.entry_fid);
   end

   // Selection of the visited entry
   always_comb begin
      id_ok = !sif.id_filter_en ||
         (sif.id_list_en ? |slot_hit : slot_hit[0]);
      port_ok = !sif.port_filter_en ||
         ((32'(sif.entry_port) < vbum_pkg::NPORT) &&
         sif.port_mask[sif.entry_port]);
      match = (state == vbum_pkg::ENG_RUN) && sif.entry_valid && id_ok && port_ok;
   end

   assign last = (sif.idx == '1);
   assign sif.busy = (state == vbum_pkg::ENG_RUN);
   assign sif.done = sif.busy && last;
   assign sif.del = match && sif.delete_en;

   // Walk every entry once per command, one per cycle
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= vbum_pkg::ENG_IDLE;
         sif.idx <= '0;
         sif.found <= '0;
      end else begin
         case (state)
            vbum_pkg::ENG_IDLE: begin
               if (sif.go) begin
                  state <= vbum_pkg::ENG_RUN;
                  sif.idx <= '0;
                  sif.found <= '0;
               end
            end
            vbum_pkg::ENG_RUN: begin
               if (match) begin
                  sif.found <= sif.found + 1'b1;
               end
               sif.idx <= sif.idx + 1'b1;
               if (last) begin
                  state <= vbum_pkg::ENG_IDLE;
               end
            end
            default: state <= vbum_pkg::ENG_IDLE;
         endcase
      end
   end
endmodule : vbum_scan

// file: vbum_top.sv
`timescale 1ns/1ns
module vbum_top #(
   parameter int VID_W = vbum_pkg::VID_W,
   parameter int MAC_AW = vbum_pkg::MAC_AW
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Avalon-MM slave
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Learning requests
   input wire logic learn_valid_in,
   input wire logic [vbum_pkg::PORT_W-1:0] learn_port_in,
   input wire logic [vbum_pkg::FID_W-1:0] learn_filter_id_in,
   input wire logic [MAC_AW-1:0] learn_index_in,
   // Receive check
   input wire logic rx_valid_in,
   input wire logic [vbum_pkg::PORT_W-1:0] rx_port_in,
   input wire logic [VID_W-1:0] rx_vid_in,
   output logic rx_valid_out,
   output logic rx_drop_out,
   // Forwarding
   input wire logic fwd_valid_in,
   input wire logic [vbum_pkg::NPORT-1:0] fwd_ports_in,
   input wire logic [3:0] fwd_aggregation_port_masks_code_in,
   input wire logic [vbum_pkg::PORT_W-1:0] fwd_egress_port_in,
   output logic fwd_valid_out,
   output logic [vbum_pkg::NPORT-1:0] fwd_ports_out,
   output logic [vbum_pkg::PORT_W-1:0] egress_key_port_out,
   // Completion interrupt
   output logic flush_irq_out
);
   localparam int NP = vbum_pkg::NPORT;
   localparam int PW = vbum_pkg::PORT_W;
   localparam int FW = vbum_pkg::FID_W;
   localparam int TW = vbum_pkg::TAG_W;
   localparam int NV = 1 << VID_W;
   localparam int NM = 1 << MAC_AW;
   localparam int NPS = 1 << PW;

   // Bus handshake
   logic ack; // Answer cycle of a request
   logic wr_fire; // Write takes effect
   logic [31:0] bem; // Byte lanes as bit mask
   logic [31:0] rd_val; // Current value at address
   logic [31:0] wd; // Write data merged over lanes
   // Control bits
   logic bulk_go; // Bulk update running
   logic tbl_go; // Table scan running
   logic [vbum_pkg::C_IRQ_EN:vbum_pkg::C_RING_EN] cfg; // Mode enables
   logic flush_done; // Sticky completion flag
   // Command parameters
   logic [VID_W-1:0] first_vid; // Bulk range start
   logic [VID_W-1:0] last_vid; // Bulk range end
   logic [NP-1:0] port_set; // Ports to add
   logic [TW-1:0] tag_sel; // Ring-tag select mask
   logic [NP-1:0] member_sel; // Spare member bits as tags
   logic [NP-1:0] scan_ports; // Port filter mask
   logic [3:0] id_sel; // Id slot pointer
   logic [FW-1:0] id_list [vbum_pkg::NSLOT]; // Filter id list
   // Tables
   logic [VID_W-1:0] v_addr; // VLAN access pointer
   logic [TW-1:0] ring_tag_bits [NV];
   logic [NP-1:0] vlan_member_ports [NV];
   logic [FW-1:0] vlan_filter_id [NV]; // Per-VID filter id
   logic [MAC_AW-1:0] m_addr; // MAC read pointer
   logic mac_valid [NM]; // Entry in use
   logic [FW-1:0] mac_fid [NM]; // Entry filter id
   logic [PW-1:0] mac_port [NM]; // Entry learned port
   // Per-port settings
   logic [NP-1:0] in_filt; // Ingress VLAN filter ports
   logic [NP-1:0] fwd_en; // Port forward enable mask
   logic [NP-1:0] learn_en; // Port learn enable mask
   logic [PW-1:0] p_sel; // Port settings pointer
   logic [PW-1:0] logical_port_number [NPS]; // Learned port id
   logic [PW-1:0] egress_key_port_number [NPS]; // Egress key id
   logic [3:0] a_sel; // Aggregation mask pointer
   logic [NP-1:0] aggregation_port_masks [vbum_pkg::NAGGR];
   // Bulk engine
   vbum_pkg::vbum_eng_state_t bu_state; // Walk state
   logic [VID_W-1:0] bu_vid; // VID being visited
   logic bu_hit; // Visited entry selected
   logic bu_done; // Last VID visited

   vbum_scan_if #(.AW(MAC_AW)) sif ();

   // Scan engine, shares the MAC table through sif
   vbum_scan #(.AW(MAC_AW)) u_scan (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .sif(sif)
   );

   assign sif.go = tbl_go;
   assign sif.id_filter_en = cfg[vbum_pkg::C_IDFILT_EN];
   assign sif.id_list_en = cfg[vbum_pkg::C_IDLIST_EN];
   assign sif.port_filter_en = cfg[vbum_pkg::C_PFILT_EN];
   assign sif.delete_en = cfg[vbum_pkg::C_DEL_EN];
   assign sif.port_mask = scan_ports;
   assign sif.id_list = id_list;
   assign sif.entry_valid = mac_valid[sif.idx];
   assign sif.entry_fid = mac_fid[sif.idx];
   assign sif.entry_port = mac_port[sif.idx];

   // Request waits one cycle, then is answered
   assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack;
   assign wr_fire = avs_write_in && ack;
   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign bem[8*b +: 8] = {8{avs_byteenable_in[b]}};
   end
   // Lanes not enabled keep the current value
   assign wd = (rd_val & ~bem) | (avs_writedata_in & bem);

   // Answer timing
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read_in || avs_write_in) && !ack;
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rd_val = 32'h0000_0000;
      case (avs_address_in)
         vbum_pkg::REG_CTRL: begin
            rd_val[vbum_pkg::C_BULK_GO] = bulk_go;
            rd_val[vbum_pkg::C_TBL_GO] = tbl_go;
            rd_val[vbum_pkg::C_IRQ_EN:vbum_pkg::C_RING_EN] = cfg;
            rd_val[vbum_pkg::C_DONE] = flush_done;
         end
         vbum_pkg::REG_RANGE: begin
            rd_val[VID_W-1:0] = first_vid;
            rd_val[vbum_pkg::RANGE_LAST_LSB +: VID_W] = last_vid;
         end
         vbum_pkg::REG_PSET: rd_val[NP-1:0] = port_set;
         vbum_pkg::REG_RMASK: begin
            rd_val[TW-1:0] = tag_sel;
            rd_val[TW +: NP] = member_sel;
         end
         vbum_pkg::REG_SPORTS: rd_val[NP-1:0] = scan_ports;
         vbum_pkg::REG_ID_SEL: rd_val[3:0] = id_sel;
         vbum_pkg::REG_ID_VAL: rd_val[FW-1:0] = id_list[id_sel];
         vbum_pkg::REG_V_ADDR: rd_val[VID_W-1:0] = v_addr;
         vbum_pkg::REG_V_DAT0: begin
            rd_val[TW-1:0] = ring_tag_bits[v_addr];
            rd_val[vbum_pkg::VD0_MEMBER_LSB +: NP] = vlan_member_ports[v_addr];
         end
         vbum_pkg::REG_V_DAT1: rd_val[FW-1:0] = vlan_filter_id[v_addr];
         vbum_pkg::REG_IN_FILT: rd_val[NP-1:0] = in_filt;
         vbum_pkg::REG_FWD_EN: rd_val[NP-1:0] = fwd_en;
         vbum_pkg::REG_LEARN_EN: rd_val[NP-1:0] = learn_en;
         vbum_pkg::REG_P_SEL: rd_val[PW-1:0] = p_sel;
         vbum_pkg::REG_P_CFG: begin
            rd_val[PW-1:0] = logical_port_number[p_sel];
            rd_val[vbum_pkg::PCFG_EGR_LSB +: PW] = egress_key_port_number[p_sel];
         end
         vbum_pkg::REG_A_SEL: rd_val[3:0] = a_sel;
         vbum_pkg::REG_A_MASK: rd_val[NP-1:0] = aggregation_port_masks[a_sel];
         vbum_pkg::REG_M_ADDR: rd_val[MAC_AW-1:0] = m_addr;
         vbum_pkg::REG_M_DATA: begin
            rd_val[FW-1:0] = mac_fid[m_addr];
            rd_val[vbum_pkg::MDATA_PORT_LSB +: PW] = mac_port[m_addr];
            rd_val[vbum_pkg::MDATA_VALID] = mac_valid[m_addr];
         end
         vbum_pkg::REG_STATUS: begin
            rd_val[0] = (bu_state == vbum_pkg::ENG_RUN);
            rd_val[1] = sif.busy;
            rd_val[vbum_pkg::STAT_FOUND_LSB +: MAC_AW+1] = sif.found;
         end
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // Read data captured while waitrequest is high
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         avs_readdata_out <= 32'h0000_0000;
      end else if (avs_read_in && !ack) begin
         avs_readdata_out <= rd_val;
      end
   end

   // Plain configuration registers
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg <= '0;
         first_vid <= '0;
         last_vid <= '0;
         port_set <= '0;
         tag_sel <= '0;
         member_sel <= '0;
         scan_ports <= '0;
         id_sel <= '0;
         v_addr <= '0;
         in_filt <= '0;
         fwd_en <= '0;
         learn_en <= '0;
         p_sel <= '0;
         a_sel <= '0;
         m_addr <= '0;
      end else if (wr_fire) begin
         case (avs_address_in)
            vbum_pkg::REG_CTRL: cfg <= wd[vbum_pkg::C_IRQ_EN:vbum_pkg::C_RING_EN];
            vbum_pkg::REG_RANGE: begin
               first_vid <= wd[VID_W-1:0];
               last_vid <= wd[vbum_pkg::RANGE_LAST_LSB +: VID_W];
            end
            vbum_pkg::REG_PSET: port_set <= wd[NP-1:0];
            vbum_pkg::REG_RMASK: begin
               tag_sel <= wd[TW-1:0];
               member_sel <= wd[TW +: NP];
            end
            vbum_pkg::REG_SPORTS: scan_ports <= wd[NP-1:0];
            vbum_pkg::REG_ID_SEL: id_sel <= wd[3:0];
            vbum_pkg::REG_V_ADDR: v_addr <= wd[VID_W-1:0];
            vbum_pkg::REG_IN_FILT: in_filt <= wd[NP-1:0];
            vbum_pkg::REG_FWD_EN: fwd_en <= wd[NP-1:0];
            vbum_pkg::REG_LEARN_EN: learn_en <= wd[NP-1:0];
            vbum_pkg::REG_P_SEL: p_sel <= wd[PW-1:0];
            vbum_pkg::REG_A_SEL: a_sel <= wd[3:0];
            vbum_pkg::REG_M_ADDR: m_addr <= wd[MAC_AW-1:0];
            default: ;
         endcase
      end
   end

   // Small indirect tables written through pointers
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < vbum_pkg::NSLOT; i++) begin
            id_list[i] <= vbum_pkg::FID_UNUSED;
         end
         for (int i = 0; i < NPS; i++) begin
            logical_port_number[i] <= PW'(i);
            egress_key_port_number[i] <= PW'(i);
         end
         for (int i = 0; i < vbum_pkg::NAGGR; i++) begin
            aggregation_port_masks[i] <= '1;
         end
      end else if (wr_fire) begin
         case (avs_address_in)
            vbum_pkg::REG_ID_VAL: id_list[id_sel] <= wd[FW-1:0];
            vbum_pkg::REG_P_CFG: begin
               logical_port_number[p_sel] <= wd[PW-1:0];
               egress_key_port_number[p_sel] <= wd[vbum_pkg::PCFG_EGR_LSB +: PW];
            end
            vbum_pkg::REG_A_MASK: aggregation_port_masks[a_sel] <= wd[NP-1:0];
            default: ;
         endcase
      end
   end

   // Go bits: software sets, engine clears at finish; set wins
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bulk_go <= 1'b0;
         tbl_go <= 1'b0;
      end else begin
         if (wr_fire && avs_address_in == vbum_pkg::REG_CTRL &&
            wd[vbum_pkg::C_BULK_GO]) begin
            bulk_go <= 1'b1;
         end else if (bu_done) begin
            bulk_go <= 1'b0;
         end
         if (wr_fire && avs_address_in == vbum_pkg::REG_CTRL &&
            wd[vbum_pkg::C_TBL_GO]) begin
            tbl_go <= 1'b1;
         end else if (sif.done) begin
            tbl_go <= 1'b0;
         end
      end
   end

   // Sticky completion flag, write one to clear; new event wins
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flush_done <= 1'b0;
      end else if (sif.done) begin
         flush_done <= 1'b1;
      end else if (wr_fire && avs_address_in == vbum_pkg::REG_CTRL &&
         avs_byteenable_in[1] && avs_writedata_in[vbum_pkg::C_DONE]) begin
         flush_done <= 1'b0;
      end
   end
   assign flush_irq_out = flush_done && cfg[vbum_pkg::C_IRQ_EN];

   // Entry selection by ring tag or spare member bits
   assign bu_hit = !cfg[vbum_pkg::C_RING_EN] ||
      |(ring_tag_bits[bu_vid] & tag_sel) ||
      |(vlan_member_ports[bu_vid] & member_sel);
   assign bu_done = (bu_state == vbum_pkg::ENG_RUN) &&
      (bu_vid == last_vid || bu_vid == '1);

   // Bulk walk, one VID per cycle, independent of the scan
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bu_state <= vbum_pkg::ENG_IDLE;
         bu_vid <= '0;
      end else begin
         case (bu_state)
            vbum_pkg::ENG_IDLE: begin
               if (bulk_go) begin
                  bu_state <= vbum_pkg::ENG_RUN;
                  bu_vid <= first_vid;
               end
            end
            vbum_pkg::ENG_RUN: begin
               bu_vid <= bu_vid + 1'b1;
               if (bu_done) begin
                  bu_state <= vbum_pkg::ENG_IDLE;
               end
            end
            default: bu_state <= vbum_pkg::ENG_IDLE;
         endcase
      end
   end

   // VLAN table; a running walk takes priority over software
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < NV; i++) begin
            ring_tag_bits[i] <= '0;
            vlan_member_ports[i] <= '0;
            vlan_filter_id[i] <= '0;
         end
      end else if (bu_state == vbum_pkg::ENG_RUN) begin
         if (bu_hit) begin
            vlan_member_ports[bu_vid] <= vlan_member_ports[bu_vid] | port_set;
         end
      end else if (wr_fire && avs_address_in == vbum_pkg::REG_V_DAT0) begin
         ring_tag_bits[v_addr] <= wd[TW-1:0];
         vlan_member_ports[v_addr] <= wd[vbum_pkg::VD0_MEMBER_LSB +: NP];
      end else if (wr_fire && avs_address_in == vbum_pkg::REG_V_DAT1) begin
         vlan_filter_id[v_addr] <= wd[FW-1:0];
      end
   end

   // MAC table: scan deletes, learning inserts elsewhere
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < NM; i++) begin
            mac_valid[i] <= 1'b0;
            mac_fid[i] <= '0;
            mac_port[i] <= '0;
         end
      end else begin
         if (sif.del) begin
            mac_valid[sif.idx] <= 1'b0;
         end
         if (learn_valid_in && 32'(learn_port_in) < NP && learn_en[learn_port_in] &&
            !(sif.del && sif.idx == learn_index_in)) begin
            mac_valid[learn_index_in] <= 1'b1;
            mac_fid[learn_index_in] <= learn_filter_id_in;
            mac_port[learn_index_in] <= logical_port_number[learn_port_in];
         end
      end
   end

   // Receive check, one cycle behind the request
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_valid_out <= 1'b0;
         rx_drop_out <= 1'b0;
      end else begin
         rx_valid_out <= rx_valid_in;
         rx_drop_out <= rx_valid_in && (32'(rx_port_in) >= NP ||
            !fwd_en[rx_port_in] ||
            (in_filt[rx_port_in] && !vlan_member_ports[rx_vid_in][rx_port_in]));
      end
   end

   // Forwarding set and egress key, one cycle behind
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fwd_valid_out <= 1'b0;
         fwd_ports_out <= '0;
         egress_key_port_out <= '0;
      end else begin
         fwd_valid_out <= fwd_valid_in;
         fwd_ports_out <= fwd_valid_in ?
            (fwd_ports_in & aggregation_port_masks[fwd_aggregation_port_masks_code_in] & fwd_en) : '0;
         egress_key_port_out <= egress_key_port_number[fwd_egress_port_in];
      end
   end
endmodule : vbum_top

// file: vbum_assertions.sv
`timescale 1ns/1ns
module vbum_assertions #(parameter int VID_W = vbum_pkg::VID_W, parameter int MAC_AW = 5) (
   // Clock, reset and bus
   input wire logic clk_sys_in, rst_n_in, avs_read_in, avs_write_in, avs_waitrequest_out,
   input wire logic [31:0] avs_readdata_out,
   // Receive and forward paths
   input wire logic rx_valid_in, rx_valid_out, rx_drop_out, fwd_valid_in, fwd_valid_out,
   input wire logic [vbum_pkg::PORT_W-1:0] rx_port_in, fwd_egress_port_in, egress_key_port_out,
   input wire logic [vbum_pkg::NPORT-1:0] fwd_ports_in, fwd_ports_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // A request opens with one wait cycle, then is answered
   sequence s_req; $rose(avs_read_in || avs_write_in); endsequence
   sequence s_ans; avs_waitrequest_out ##1 !avs_waitrequest_out; endsequence
   property p_bus_answer; s_req |-> s_ans; endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
   // Read data only moves when a read is captured
   property p_rd_hold; !(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_rx_follow; rx_valid_in |=> rx_valid_out; endproperty
   a_rx_follow: assert property (p_rx_follow) else $error("rx result lost");
   // Unknown ports can never pass
   property p_rx_bad; rx_valid_in && rx_port_in > 4'hA |=> rx_drop_out; endproperty
   a_rx_bad: assert property (p_rx_bad) else $error("bad port passed");
   property p_fwd_idle; !fwd_valid_in |=> !fwd_valid_out && fwd_ports_out == '0; endproperty
   a_fwd_idle: assert property (p_fwd_idle) else $error("idle forward");
   // Masks only ever remove ports
   property p_fwd_sub;
      fwd_valid_in |=> fwd_valid_out && (fwd_ports_out & ~$past(fwd_ports_in)) == '0;
   endproperty
   a_fwd_sub: assert property (p_fwd_sub) else $error("port added");
   // Key number only changes with its input or a register write
   property p_key;
      $past(rst_n_in) && !$past(avs_write_in) && $stable(fwd_egress_port_in)
         |=> $stable(egress_key_port_out);
   endproperty
   a_key: assert property (p_key) else $error("egress key moved");
endmodule : vbum_assertions
bind vbum_top vbum_assertions #(.VID_W(VID_W), .MAC_AW(MAC_AW)) u_chk (.clk_sys_in, .rst_n_in,
   .avs_read_in, .avs_write_in, .avs_waitrequest_out, .avs_readdata_out, .rx_valid_in,
   .rx_valid_out, .rx_drop_out, .fwd_valid_in, .fwd_valid_out, .rx_port_in, .fwd_egress_port_in,
   .egress_key_port_out, .fwd_ports_in, .fwd_ports_out);

// file: testbench.sv
`timescale 1ns/1ns
module testbench;
   // Stimulus, all quiet at time zero
   logic clk_sys_in = 0, rst_n_in = 0, rd = 0, wr = 0, lv = 0, rv = 0, fv = 0;
   logic [7:0] adr = '0;
   logic [31:0] wdat = '0, rdat;
   logic [3:0] lp = '0, rp = '0, fc = '0, fe = '0, eko;
   logic [16:0] lf = '0;
   logic [4:0] li = '0;
   logic [5:0] rvid = '0;
   logic [10:0] fp = '0, fpo;
   logic [31:0] rdo;
   logic wreq, rvo, rdrop, fvo, irq;
   int err_count = 0, comparisons = 0, cyc = 0;
   // Vid, tag, member before, member after the bulk update
   int vt[8][4] = '{'{4, 1, 3, 3}, '{10, 3, 131, 387}, '{20, 2, 128, 384}, '{31, 1, 3, 3},
      '{50, 2, 128, 384}, '{51, 2, 128, 128}, '{12, 32768, 1024, 1280}, '{63, 2, 0, 0}};
   // Port, filter id, still valid after the flush
   int lt[5][3] = '{'{7, 10, 0}, '{8, 25, 0}, '{7, 26, 1}, '{3, 10, 1}, '{8, 131071, 1}};
   always #20 clk_sys_in = ~clk_sys_in;
   vbum_top uut (.clk_sys_in, .rst_n_in, .avs_address_in(adr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hF),
      .avs_readdata_out(rdo), .avs_waitrequest_out(wreq), .learn_valid_in(lv),
      .learn_port_in(lp), .learn_filter_id_in(lf), .learn_index_in(li), .rx_valid_in(rv),
      .rx_port_in(rp), .rx_vid_in(rvid), .rx_valid_out(rvo), .rx_drop_out(rdrop),
      .fwd_valid_in(fv), .fwd_ports_in(fp), .fwd_aggregation_port_masks_code_in(fc), .fwd_egress_port_in(fe),
      .fwd_valid_out(fvo), .fwd_ports_out(fpo), .egress_key_port_out(eko), .flush_irq_out(irq));
   task automatic chk(input string nm, input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // One bus access, held until waitrequest is seen low
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do @(posedge clk_sys_in); while (wreq !== 1'b0);
      rdat = rdo;
      rd <= 0;
      wr <= 0;
   endtask : acc
   task automatic rxc(input int p, v, e);
      @(posedge clk_sys_in);
      rv <= 1;
      rp <= 4'(p);
      rvid <= 6'(v);
      @(posedge clk_sys_in);
      rv <= 0;
      #1 chk("drop", rdrop, e);
      chk("rx valid", rvo, 1);
   endtask : rxc
   task automatic fwc(input int c, k, e, m);
      @(posedge clk_sys_in);
      fv <= 1;
      fp <= 11'h180;
      fc <= 4'(c);
      fe <= 4'(k);
      @(posedge clk_sys_in);
      fv <= 0;
      #1 chk("fwd", fpo, m);
      chk("fwd valid", fvo, 1);
      chk("key", eko, e);
   endtask : fwc
   task automatic give_verdict;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict
   // Hang guard, far above the few hundred cycles needed
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      repeat (20) @(posedge clk_sys_in);
      rst_n_in <= 1;
      acc(1, vbum_pkg::REG_LEARN_EN, 32'h0000_07FF);
      acc(1, vbum_pkg::REG_FWD_EN, 32'h0000_07FF);
      acc(1, vbum_pkg::REG_IN_FILT, 32'h0000_0180);
      acc(1, vbum_pkg::REG_P_SEL, 32'h0000_0003);
      acc(1, vbum_pkg::REG_P_CFG, 32'h0000_0059);
      foreach (vt[i]) begin
         acc(1, vbum_pkg::REG_V_ADDR, vt[i][0]);
         acc(1, vbum_pkg::REG_V_DAT0, vt[i][2] << 16 | vt[i][1]);
      end
      foreach (lt[i]) begin
         @(posedge clk_sys_in);
         lv <= 1;
         lp <= 4'(lt[i][0]);
         lf <= 17'(lt[i][1]);
         li <= 5'(i);
      end
      @(posedge clk_sys_in) lv <= 0;
      for (int s = 0; s < 16; s++) begin
         acc(1, vbum_pkg::REG_ID_SEL, s);
         acc(1, vbum_pkg::REG_ID_VAL, s == 0 ? 10 : s == 1 ? 25 : 32'h0001_FFFF);
      end
      acc(1, vbum_pkg::REG_SPORTS, 32'h0000_0180);
      acc(1, vbum_pkg::REG_PSET, 32'h0000_0100);
      acc(1, vbum_pkg::REG_RANGE, 32'h0032_000A);
      acc(1, vbum_pkg::REG_RMASK, 32'h0400_0002);
      // Flush first, then the bulk update beside it
      acc(1, vbum_pkg::REG_CTRL, 32'h0000_00FA);
      acc(1, vbum_pkg::REG_CTRL, 32'h0000_00FD);
      do acc(0, vbum_pkg::REG_CTRL, 0); while (rdat[1:0] !== 2'b00);
      chk("irq", irq, 1);
      acc(0, vbum_pkg::REG_STATUS, 0);
      chk("status", rdat[13:0], 32'h0000_0200);
      foreach (vt[i]) begin
         acc(1, vbum_pkg::REG_V_ADDR, vt[i][0]);
         acc(0, vbum_pkg::REG_V_DAT0, 0);
         chk("vlan", rdat, vt[i][3] << 16 | vt[i][1]);
      end
      foreach (lt[i]) begin
         acc(1, vbum_pkg::REG_M_ADDR, i);
         acc(0, vbum_pkg::REG_M_DATA, 0);
         chk("mac valid", rdat[31], lt[i][2]);
         if (i == 3)
            chk("logical", rdat[20:17], 9);
      end
      acc(1, vbum_pkg::REG_CTRL, 32'h0000_01F8);
      @(posedge clk_sys_in);
      chk("irq clear", irq, 0);
      // Second scan: slot 0 only, no delete, interrupt masked
      acc(1, vbum_pkg::REG_CTRL, 32'h0000_0012);
      do acc(0, vbum_pkg::REG_CTRL, 0); while (rdat[1] !== 1'b0);
      chk("irq off", irq, 0);
      acc(0, vbum_pkg::REG_STATUS, 0);
      chk("found", rdat[13:0], 32'h0000_0100);
      rxc(8, 20, 0);
      rxc(8, 51, 1);
      rxc(7, 51, 0);
      rxc(2, 4, 0);
      rxc(12, 20, 1);
      acc(1, vbum_pkg::REG_A_SEL, 32'h0000_0002);
      acc(1, vbum_pkg::REG_A_MASK, 32'h0000_06FF);
      fwc(2, 3, 5, 11'h080);
      fwc(0, 4, 4, 11'h180);
      give_verdict();
   end
endmodule : testbench
